// ---- design/perf_event_pkg.sv ----
// Shared constants and carrier types for the performance event counters.
package perf_event_pkg;

    // ************************************************************
    // Widths and control register layout
    // ************************************************************
    localparam int          CTR_W        = 20;
    localparam int          CTL_W        = 64;
    localparam int          CTR0_LSB     = 44;
    localparam int          CTR1_LSB     = 12;
    localparam int          MODE_BIT     = 4;
    localparam int          SEL_LSB      = 2;
    localparam logic [63:0] CTL_RESET    = 64'h0;
    localparam logic [19:0] CTR_RESET    = 20'h0;
    localparam logic [19:0] CTR_THRESH   = 20'hFFFFF;

    // ************************************************************
    // Event rates and timing
    // ************************************************************
    localparam logic [3:0]  RETIRE_CAP   = 4'h8;
    localparam logic [3:0]  RETIRE_MAX   = 4'hB;
    localparam int          MISS_LEAD    = 3;
    localparam int          BACKLOG_W    = 6;

    // ************************************************************
    // Mode and event select encodings
    // ************************************************************
    localparam logic        MODE_TOTAL   = 1'b0;
    localparam logic        MODE_SAMPLE  = 1'b1;
    localparam logic [1:0]  SEL_RET_CYC  = 2'h0;
    localparam logic [1:0]  SEL_CYC_NONE = 2'h1;
    localparam logic [1:0]  SEL_RET_MISS = 2'h2;
    localparam logic [1:0]  SEL_CYC_REPL = 2'h3;

    // ************************************************************
    // Carrier types
    // ************************************************************
    typedef struct packed {
        logic [3:0] retire_count;
        logic [3:0] squash_count;
        logic [2:0] fetch_count;
        logic       fetch_conditional_move;
        logic       cache_miss;
        logic       replay_trap;
    } pipe_events_s;

    typedef struct packed {
        logic       system_count_enable;
        logic       process_count_enable;
        logic       counter_zero_enable;
        logic       counter_one_enable;
        logic [1:0] counter_interrupt_enable;
    } count_enables_s;

    typedef struct packed {
        logic [CTR_W-1:0]     ctr0;
        logic [CTR_W-1:0]     ctr1;
        logic                 mode;
        logic [1:0]           sel;
        logic [BACKLOG_W-1:0] backlog;
        logic [MISS_LEAD-1:0] miss_pipe;
        logic                 conditional_move_hold;
        logic [1:0]           pending;
        logic [1:0]           latch;
        logic [1:0]           arm;
        logic                 priv_q;
        logic                 irq;
        logic [CTL_W-1:0]     rdata;
    } perf_state_s;

endpackage

// ---- design/perf_event_counters.sv ----
// Two 20-bit performance event counters with overflow interrupt logic.
//
// Functional notes
// [R1] Counters keep counting past overflow, wrapping to zero.
// [R2] Software keeps counter 0 writes within 0 to 2^20-16.
// [R3] Software keeps counter 1 writes within 0 to 2^20-4.
// [R4] Control register holds both counter values, writable and readable.
// [R5] Mode bit zero selects event-total mode, one selects sampling.
// [R6] Counter counts when its enable and system or process enable set.
// [R7] Overflow with interrupt enabled sets that counter's pending bit.
// [R8] Counter 0 adds at most 8 retires per cycle; excess deferred.
// [R9] Cycle selection adds exactly one per enabled cycle.
// [R10] Squashed instructions are not counted as retired.
// [R11] Select field maps events to counters per fixed table.
// [R12] Cache miss event is taken three cycles ahead of the window.
// [R13] Replay selection counts memory-unit replay traps.
// [R14] Write at threshold raises interrupt on privileged exit, even disabled.
// [R15] No counter interrupt is signalled while in privileged mode; counter_irq_out is registered and drops one cycle after entry.
// [R16] Interrupt clear pulse clears pending counter interrupts.
// [R17] Reset software writes both counters to zero twice.
// [R18] Software never leaves a disabled counter one cycle from overflow.
// [R19] Reads while disabled may show a small extra increment.
// [R20] Counters are readable at any time.
// [R21] Sampling mode counts squashed no-ops as fetched instructions.
// [R22] Conditional move counts as two fetches in consecutive cycles.
// [R23] Mode bit one places counters in sampling mode; only counter 0 changes source, counter 1 still follows the select field.
// [R24] Wrap past all-ones sets a latch that counter writes clear; a write while that counter is at all-ones sets it instead.
module perf_event_counters (
    // Clock and reset
    input  wire logic                          mclk_in,
    input  wire logic                          rst_in,
    // Privileged register move port
    input  wire logic                          ctl_write_in,
    input  wire logic [63:0]                   ctl_wdata_in,
    output logic      [63:0]                   ctl_rdata_out,
    // Core state and enables
    input  wire logic                          privileged_mode_in,
    input  wire logic                          interrupt_clear_in,
    input  wire perf_event_pkg::count_enables_s enables_in,
    // Pipeline events
    input  wire perf_event_pkg::pipe_events_s  events_in,
    // Interrupt status
    output logic      [1:0]                    counter_interrupt_pending_out,
    output logic      [1:0]                    overflow_latch_out,
    output logic                               counter_irq_out
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [20:0] add_wrap(input logic [19:0] ctr, input logic [4:0] inc);
        add_wrap = {1'b0, ctr} + {16'h0, inc};
    endfunction

    function automatic logic [63:0] pack_ctl(input perf_event_pkg::perf_state_s s);
        logic [63:0] v;
        v = perf_event_pkg::CTL_RESET;
        v[perf_event_pkg::CTR0_LSB +: perf_event_pkg::CTR_W] = s.ctr0;
        v[perf_event_pkg::CTR1_LSB +: perf_event_pkg::CTR_W] = s.ctr1;
        v[perf_event_pkg::MODE_BIT] = s.mode;
        v[perf_event_pkg::SEL_LSB +: 2] = s.sel;
        pack_ctl = v;
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    perf_event_pkg::perf_state_s st;
    perf_event_pkg::perf_state_s next_st;

    logic                                  en0;
    logic                                  en1;
    logic                                  priv_exit;
    logic [3:0]                            net_retire;
    logic [6:0]                            total_retire;
    logic [4:0]                            inc0;
    logic [4:0]                            inc1;
    logic [20:0]                           sum0;
    logic [20:0]                           sum1;
    logic [1:0]                            wrap;
    logic [1:0]                            thresh;
    logic                                  retire_path;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_st = st;
        en0 = enables_in.counter_zero_enable &&
              (enables_in.system_count_enable || enables_in.process_count_enable); // [R6]
        en1 = enables_in.counter_one_enable &&
              (enables_in.system_count_enable || enables_in.process_count_enable); // [R6]
        priv_exit = st.priv_q && !privileged_mode_in;
        retire_path = (st.mode == perf_event_pkg::MODE_TOTAL) && !st.sel[0]; // [R5] [R11]

        // Squashed instructions are removed before they reach the counter.
        if (events_in.retire_count > events_in.squash_count) begin
            net_retire = events_in.retire_count - events_in.squash_count; // [R10]
        end else begin
            net_retire = 4'h0; // [R10]
        end
        total_retire = {1'b0, st.backlog} + {3'h0, net_retire};

        // Counter 0 source.
        inc0 = 5'h0;
        if (st.mode == perf_event_pkg::MODE_SAMPLE) begin
            // Fetch count already includes squashed no-ops; the second half of
            // a conditional move is added one cycle later.
            inc0 = {2'h0, events_in.fetch_count} + {4'h0, st.conditional_move_hold}; // [R21] [R22] [R23]
        end else if (!st.sel[0]) begin
            if (total_retire > {3'h0, perf_event_pkg::RETIRE_CAP}) begin
                inc0 = {1'b0, perf_event_pkg::RETIRE_CAP}; // [R8]
            end else begin
                inc0 = total_retire[4:0]; // [R8]
            end
        end else begin
            inc0 = 5'h1; // [R9]
        end

        // Counter 1 source.
        unique case (st.sel)
            perf_event_pkg::SEL_RET_CYC:  inc1 = 5'h1; // [R9] [R11]
            perf_event_pkg::SEL_CYC_NONE: inc1 = 5'h0; // [R11]
            perf_event_pkg::SEL_RET_MISS: inc1 = {4'h0, st.miss_pipe[perf_event_pkg::MISS_LEAD-1]}; // [R12]
            perf_event_pkg::SEL_CYC_REPL: inc1 = {4'h0, events_in.replay_trap}; // [R13]
        endcase

        next_st.miss_pipe = {st.miss_pipe[perf_event_pkg::MISS_LEAD-2:0], events_in.cache_miss}; // [R12]
        next_st.conditional_move_hold = events_in.fetch_conditional_move && (st.mode == perf_event_pkg::MODE_SAMPLE); // [R22]
        next_st.priv_q = privileged_mode_in;

        sum0 = add_wrap(st.ctr0, inc0);
        sum1 = add_wrap(st.ctr1, inc1);
        wrap = 2'h0;
        if (en0) begin
            next_st.ctr0 = sum0[19:0]; // [R1]
            wrap[0] = sum0[20]; // [R24]
            if (retire_path) begin
                // Retires above the cap wait here; a sustained burst can overflow the 6-bit backlog.
                next_st.backlog = total_retire[5:0] - {2'h0, inc0[3:0]}; // [R8]
            end
        end
        if (en1) begin
            next_st.ctr1 = sum1[19:0]; // [R1]
            wrap[1] = sum1[20]; // [R24]
        end

        thresh = {st.ctr1 == perf_event_pkg::CTR_THRESH, st.ctr0 == perf_event_pkg::CTR_THRESH};
        if (ctl_write_in) begin
            next_st.ctr0 = ctl_wdata_in[perf_event_pkg::CTR0_LSB +: perf_event_pkg::CTR_W]; // [R4]
            next_st.ctr1 = ctl_wdata_in[perf_event_pkg::CTR1_LSB +: perf_event_pkg::CTR_W]; // [R4]
            next_st.mode = ctl_wdata_in[perf_event_pkg::MODE_BIT]; // [R5] [R23]
            next_st.sel = ctl_wdata_in[perf_event_pkg::SEL_LSB +: 2]; // [R11]
            next_st.backlog = '0;
            // A write from threshold sets the latch; a second write clears it.
            next_st.latch = thresh; // [R24] [R17]
            // A later write must not cancel an exit interrupt armed by an earlier one.
            next_st.arm = (priv_exit ? 2'h0 : st.arm) | thresh; // [R14]
        end else begin
            next_st.latch = st.latch | wrap; // [R24]
            next_st.arm = priv_exit ? 2'h0 : st.arm; // [R14]
        end

        // Set wins over a clear in the same cycle.
        next_st.pending = (wrap & enables_in.counter_interrupt_enable) // [R7]
                        | (st.arm & {2{priv_exit}}) // [R14]
                        | (st.pending & ~{2{interrupt_clear_in}}); // [R16]
        next_st.irq = (|next_st.pending) && !privileged_mode_in; // [R15]
        // The read value lags one cycle, which stays within the allowed read skew.
        next_st.rdata = pack_ctl(st); // [R20] [R19]
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign ctl_rdata_out = st.rdata;
    assign counter_interrupt_pending_out = st.pending;
    assign overflow_latch_out = st.latch;
    assign counter_irq_out = st.irq;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    a_cycle_step: assert property ( // [R9]
        (en0 && !ctl_write_in && st.mode == perf_event_pkg::MODE_TOTAL && st.sel[0])
        |=> st.ctr0 == $past(st.ctr0) + 20'h1)
        else $error("cycle count did not step by one");

    a_retire_cap: assert property ( // [R8]
        (!ctl_write_in && st.mode == perf_event_pkg::MODE_TOTAL && !st.sel[0])
        |=> (st.ctr0 - $past(st.ctr0)) <= 20'h8)
        else $error("retire increment above eight");

    a_retire_defer: assert property ( // [R8]
        (en0 && retire_path && !ctl_write_in && st.backlog == 6'h0
         && events_in.retire_count == 4'hB && events_in.squash_count == 4'h0)
        |=> st.backlog == 6'h3)
        else $error("excess retires not deferred");

    a_count_gate: assert property ( // [R6]
        (!en0 && !ctl_write_in) |=> $stable(st.ctr0))
        else $error("counter moved while disabled");

    a_wrap_go_on: assert property ( // [R1]
        (en0 && !ctl_write_in && st.sel[0] && st.mode == perf_event_pkg::MODE_TOTAL
         && st.ctr0 == 20'hFFFFF) |=> st.ctr0 == 20'h0 ##1
        (!$past(en0) || $past(ctl_write_in) || st.ctr0 != 20'h0))
        else $error("counter stopped at overflow");

    a_pend_set: assert property ( // [R7]
        (wrap[1] && enables_in.counter_interrupt_enable[1]) |=> st.pending[1])
        else $error("overflow did not raise pending");

    a_irq_priv: assert property ( // [R15]
        $past(privileged_mode_in) |-> !counter_irq_out)
        else $error("interrupt raised in privileged mode");

    a_pend_clear: assert property ( // [R16]
        (interrupt_clear_in && wrap == 2'h0 && !priv_exit) |=> st.pending == 2'h0)
        else $error("clear did not drop pending");

    a_write_load: assert property ( // [R4]
        ctl_write_in |=> st.ctr1 == $past(ctl_wdata_in[31:12]) ##1
        ctl_rdata_out[31:12] == $past(st.ctr1))
        else $error("control write not loaded");

    a_sel_undef: assert property ( // [R11]
        (st.sel == perf_event_pkg::SEL_CYC_NONE && !ctl_write_in) |=> $stable(st.ctr1))
        else $error("undefined select moved counter one");

    a_miss_lead: assert property ( // [R12]
        (en1 && st.sel == perf_event_pkg::SEL_RET_MISS && !ctl_write_in
         && $past(events_in.cache_miss, 3)) |=> st.ctr1 == $past(st.ctr1) + 20'h1)
        else $error("cache miss not counted three cycles later");

    a_thresh_arm: assert property ( // [R14]
        (ctl_write_in && st.ctr0 == 20'hFFFFF) ##1 (!ctl_write_in throughout
        (privileged_mode_in [*1] ##1 !privileged_mode_in)) |=> st.pending[0])
        else $error("threshold write did not interrupt on exit");

    a_ctr1_gate: assert property ( // [R6]
        (!en1 && !ctl_write_in) |=> $stable(st.ctr1))
        else $error("counter one moved while disabled");

    a_write_beat: assert property ( // [R4]
        ctl_write_in |=> st.ctr0 == $past(ctl_wdata_in[63:44]))
        else $error("control write lost counter zero");

    a_mode_load: assert property ( // [R5] [R23]
        ctl_write_in |=> st.mode == $past(ctl_wdata_in[4]))
        else $error("mode bit not loaded");

    a_sel_load: assert property ( // [R11]
        ctl_write_in |=> st.sel == $past(ctl_wdata_in[3:2]))
        else $error("select field not loaded");

    a_read_image: assert property ( // [R20]
        1'b1 |=> ctl_rdata_out[63:44] == $past(st.ctr0))
        else $error("read image lost counter zero");

    a_spare_zero: assert property ( // [R4]
        ctl_rdata_out[43:32] == 12'h0 && ctl_rdata_out[11:5] == 7'h0
        && ctl_rdata_out[1:0] == 2'h0)
        else $error("unused read bits not zero");

    a_squash_drop: assert property ( // [R10]
        (en0 && retire_path && !ctl_write_in && st.backlog == 6'h0
         && events_in.retire_count <= events_in.squash_count) |=> $stable(st.ctr0))
        else $error("squashed retire was counted");

    a_sample_fetch: assert property ( // [R21] [R22]
        (en0 && st.mode == perf_event_pkg::MODE_SAMPLE && !ctl_write_in)
        |=> st.ctr0 == $past(st.ctr0) + 20'($past(events_in.fetch_count))
            + 20'($past(st.conditional_move_hold)))
        else $error("fetch count not added");

    a_conditional_move_hold: assert property ( // [R22]
        (events_in.fetch_conditional_move && st.mode == perf_event_pkg::MODE_SAMPLE) |=> st.conditional_move_hold)
        else $error("second half not held");

    a_replay_count: assert property ( // [R13]
        (en1 && st.sel == perf_event_pkg::SEL_CYC_REPL && !ctl_write_in)
        |=> st.ctr1 == $past(st.ctr1) + 20'($past(events_in.replay_trap)))
        else $error("replay trap not counted");

    a_ctr1_cycle: assert property ( // [R9]
        (en1 && st.sel == perf_event_pkg::SEL_RET_CYC && !ctl_write_in)
        |=> st.ctr1 == $past(st.ctr1) + 20'h1)
        else $error("counter one cycle step wrong");

    a_latch_set: assert property ( // [R24]
        (wrap[0] && !ctl_write_in) |=> st.latch[0])
        else $error("wrap did not set latch");

    a_latch_hold: assert property ( // [R24]
        (st.latch[0] && !ctl_write_in) |=> st.latch[0])
        else $error("latch dropped without write");

    a_irq_follow: assert property ( // [R7]
        (|st.pending && !privileged_mode_in && !interrupt_clear_in) |=> counter_irq_out)
        else $error("pending did not raise irq");

    a_pend_sticky: assert property ( // [R16]
        (st.pending[0] && !interrupt_clear_in) |=> st.pending[0])
        else $error("pending dropped without clear");

    a_arm_deliver: assert property ( // [R14]
        (st.arm[0] && priv_exit) |=> st.pending[0])
        else $error("armed exit did not interrupt");

    a_arm_clear: assert property ( // [R14]
        (priv_exit && !ctl_write_in) |=> st.arm == 2'h0)
        else $error("arm kept after exit");

    a_pend_zero: assert property ( // [R7]
        (wrap[0] && enables_in.counter_interrupt_enable[0]) |=> st.pending[0])
        else $error("counter zero wrap not pending");

    a_backlog_zero: assert property ( // [R8]
        ctl_write_in |=> st.backlog == 6'h0)
        else $error("write kept retire backlog");

    a_miss_pipe: assert property ( // [R12]
        1'b1 |=> st.miss_pipe[0] == $past(events_in.cache_miss))
        else $error("cache miss not staged");

endmodule

// ---- dv/pipe_model.sv ----
// Behavioural model of the core pipeline that feeds events to the counters.
module pipe_model (
    // Clock and reset
    input  wire logic                    mclk_in,
    input  wire logic                    rst_in,
    // Stimulus control
    input  wire logic [31:0]             rnd_in,
    input  wire logic                    quiet_in,
    input  wire logic                    burst_in,
    // Event outputs
    output perf_event_pkg::pipe_events_s events_out
);
    timeunit 1ns;
    timeprecision 1ps;

    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in || quiet_in) begin
            events_out <= '0;
        end else begin
            // Eleven retires only come in short bursts, never sustained.
            events_out.retire_count <= burst_in ? 4'(rnd_in[3:0] % 12) : 4'(rnd_in[3:0] % 9);
            events_out.squash_count <= {2'h0, rnd_in[5:4]};
            events_out.fetch_count  <= 3'(rnd_in[8:6] % 5);
            events_out.fetch_conditional_move   <= rnd_in[9] & ~events_out.fetch_conditional_move;
            events_out.cache_miss   <= rnd_in[10];
            events_out.replay_trap  <= rnd_in[11];
        end
    end
endmodule

// ---- dv/testbench.sv ----
// Self-checking testbench for the performance event counters.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // ********
    // Signals
    // ********
    logic                           mclk_in = 1'b0;
    logic                           rst_in = 1'b1;
    logic                           ctl_write_in = 1'b0;
    logic [63:0]                    ctl_wdata_in = 64'h0;
    logic [63:0]                    ctl_rdata_out;
    logic                           privileged_mode_in = 1'b0;
    logic                           interrupt_clear_in = 1'b0;
    perf_event_pkg::count_enables_s enables_in;
    logic [5:0]                     en_rnd = 6'h0;
    logic [5:0]                     en_fix = 6'h0;
    perf_event_pkg::pipe_events_s   ev;
    logic [1:0]                     pend;
    logic [1:0]                     latch;
    logic                           irq;
    logic [31:0]                    rnd = 32'd57004;
    logic                           quiet = 1'b1;
    logic                           burst = 1'b0;
    logic                           en_rand = 1'b0;
    logic [19:0]                    c0, c1;
    logic                           md;
    logic [1:0]                     sl;
    logic [5:0]                     bl, net, tot, inc;
    logic [2:0]                     pipe;
    logic                           hold, en0, en1;
    logic [63:0]                    img;
    int                             miscompares = 0;
    int                             num_checks = 0;

    perf_event_counters i_dut (.mclk_in(mclk_in), .rst_in(rst_in), .ctl_write_in(ctl_write_in),
        .ctl_wdata_in(ctl_wdata_in), .ctl_rdata_out(ctl_rdata_out),
        .privileged_mode_in(privileged_mode_in), .interrupt_clear_in(interrupt_clear_in),
        .enables_in(enables_in), .events_in(ev), .counter_interrupt_pending_out(pend),
        .overflow_latch_out(latch), .counter_irq_out(irq));
    pipe_model i_pipe (.mclk_in(mclk_in), .rst_in(rst_in), .rnd_in(rnd), .quiet_in(quiet),
        .burst_in(burst), .events_out(ev));

    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        v = v ^ (v << 5);
        return v;
    endfunction

    always #5 mclk_in = ~mclk_in;

    always @(posedge mclk_in) begin
        rnd <= xs(rnd);
        en_rnd <= {rnd[15:12], 2'h0};
    end

    assign enables_in = en_rand ? en_rnd : en_fix;

    // ********
    // Reference model: the read image trails the state by one cycle.
    // ********
    assign en0 = enables_in.counter_zero_enable & (enables_in.system_count_enable
                 | enables_in.process_count_enable);
    assign en1 = enables_in.counter_one_enable & (enables_in.system_count_enable
                 | enables_in.process_count_enable);
    assign net = (ev.retire_count > ev.squash_count) ? 6'(ev.retire_count - ev.squash_count) : 6'h0;
    assign tot = bl + net;
    assign inc = (tot > 6'h8) ? 6'h8 : tot;

    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            {c0, c1, md, sl, bl, pipe, hold, img} <= '0;
        end else begin
            pipe <= {pipe[1:0], ev.cache_miss};
            hold <= ev.fetch_conditional_move;
            if (ctl_write_in) begin
                {c0, c1, md, sl, bl} <= {ctl_wdata_in[63:44], ctl_wdata_in[31:12],
                                         ctl_wdata_in[4:2], 6'h0};
            end else begin
                if (en0 && md) c0 <= c0 + 20'(ev.fetch_count) + 20'(hold);
                else if (en0 && sl[0]) c0 <= c0 + 20'h1;
                else if (en0) begin
                    c0 <= c0 + 20'(inc);
                    bl <= tot - inc;
                end
                if (en1 && sl != 2'h1) c1 <= c1 + ((sl == 2'h0) ? 20'h1 : (sl == 2'h2) ?
                    20'(pipe[2]) : 20'(ev.replay_trap));
            end
            img <= {c0, 12'h0, c1, 7'h0, md, sl, 2'h0};
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    always @(negedge mclk_in) if (!rst_in) check(ctl_rdata_out, img, "control image");

    task automatic close_out();
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Events are held quiet for four cycles so no delayed miss straddles the write.
    task automatic do_write(input logic [19:0] v0, input logic [19:0] v1, input logic [2:0] ms);
        @(posedge mclk_in) quiet <= 1'b1;
        repeat (4) @(posedge mclk_in);
        ctl_wdata_in <= {v0, 12'h0, v1, 7'h0, ms, 2'h0};
        ctl_write_in <= 1'b1;
        @(posedge mclk_in) ctl_write_in <= 1'b0;
    endtask

    task automatic clear_irq();
        @(posedge mclk_in) interrupt_clear_in <= 1'b1;
        @(posedge mclk_in) interrupt_clear_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
    endtask

    initial begin
        repeat (20000) @(posedge mclk_in);
        miscompares++;
        close_out();
    end

    initial begin
        repeat (20) @(posedge mclk_in);
        rst_in <= 1'b0;
        do_write(20'h0, 20'h0, 3'h0);
        do_write(20'h0, 20'h0, 3'h0);
        @(posedge mclk_in) check({62'h0, latch}, 64'h0, "latch after init");
        for (int i = 0; i < 8; i++) begin
            do_write((rnd[19:0] > 20'hFFFF0) ? 20'hFFFF0 : rnd[19:0],
                     (rnd[31:12] > 20'hFFFFC) ? 20'hFFFFC : rnd[31:12], 3'(i));
            en_rand <= (i < 4);
            en_fix <= 6'h3C;
            quiet <= 1'b0;
            repeat (200) @(posedge mclk_in);
            $display("select %0d mode %0d finished", i % 4, i / 4);
        end
        en_rand <= 1'b0;
        do_write(20'h0, 20'h0, 3'h0);
        burst <= 1'b1;
        quiet <= 1'b0;
        repeat (40) @(posedge mclk_in);
        burst <= 1'b0;
        repeat (20) @(posedge mclk_in);
        $display("retire burst finished");
        clear_irq();
        en_fix <= 6'h2E;
        do_write(20'hFFFF0, 20'hFFFFC, 3'h0);
        repeat (6) @(posedge mclk_in);
        check({62'h0, pend}, 64'h2, "pending after wrap");
        check({63'h0, latch[1]}, 64'h1, "latch after wrap");
        check({63'h0, irq}, 64'h1, "irq outside privileged");
        privileged_mode_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        check({63'h0, irq}, 64'h0, "irq in privileged");
        clear_irq();
        check({62'h0, pend}, 64'h0, "pending after clear");
        privileged_mode_in <= 1'b0;
        $display("wrap interrupt finished");
        en_fix <= 6'h0;
        do_write(20'hFFFF0, 20'h0, 3'h1);
        en_fix <= 6'h28;
        repeat (15) @(posedge mclk_in);
        en_fix <= 6'h0;
        privileged_mode_in <= 1'b1;
        do_write(20'h0, 20'h0, 3'h1);
        repeat (2) @(posedge mclk_in);
        check({63'h0, latch[0]}, 64'h1, "latch at threshold write");
        do_write(20'h0, 20'h0, 3'h1);
        repeat (2) @(posedge mclk_in);
        check({63'h0, latch[0]}, 64'h0, "latch after second write");
        check({62'h0, pend}, 64'h0, "pending in privileged");
        privileged_mode_in <= 1'b0;
        repeat (4) @(posedge mclk_in);
        check({62'h0, pend}, 64'h1, "pending on exit");
        check({63'h0, irq}, 64'h1, "irq on exit");
        clear_irq();
        check({62'h0, pend}, 64'h0, "pending suppressed");
        $display("threshold write finished");
        close_out();
    end
endmodule
